/* File: adg_port.sv */
// sixteen-pin gpio port shared with the multiplexed address/data bus
`include "adg_map.svh"

module adg_port (
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire adg_pkg::adg_bus_req_t bus_req,
    output logic [15:0] rdata,
    // pins, split into input, output and enable
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe,
    // external bus controller side
    input wire adg_pkg::adg_drive_t muxed_addr_data_drive,
    output logic [15:0] muxed_addr_data_bit,
    // flash programming mode
    input wire logic flash_mode,
    output logic flash_mode_pin,
    // bus configuration seen from the bus controller
    input wire logic separate_bus_mode_bit,
    input wire logic [3:0] area_bus_width_bits,
    output logic upper_bus_conflict
);

    // register state
    logic [15:0] port_output_latch; // output data latch
    logic [15:0] pin_direction_reg; // 1 input, 0 output
    logic [15:0] pin_function_select; // 1 bus pin, 0 port pin
    logic [15:0] pin_level; // synchronised pin levels
    logic [15:0] latch_view; // latch as software reads it

    // address decode
    logic hit_latch;
    logic hit_dir;
    logic hit_func;
    logic hit_stat;
    logic hit_high; // odd byte address selects the high byte
    logic wr_latch;
    logic wr_dir;
    logic wr_func;

    // next values
    logic [15:0] next_latch;
    logic [15:0] next_dir;
    logic [15:0] next_func;
    logic [15:0] next_rdata;

    // merge a write into a 16-bit register by access size
    function automatic logic [15:0] merge_write(
        input logic [15:0] cur,
        input adg_pkg::adg_acc_t acc,
        input logic high,
        input logic [15:0] wd
    );
        logic [15:0] res;
        logic [3:0] idx;
        res = cur;
        idx = {high, wd[`ADG_BIT_IDX_MSB:0]};
        unique case (acc)
            adg_pkg::adg_acc_word: begin
                // a word write at the odd address is misaligned and dropped
                if (!high) begin
                    res = wd;
                end
            end
            adg_pkg::adg_acc_byte: begin
                // high byte lane carries bits 8 to 15 in its bits 0 to 7
                if (high) begin
                    res[15:8] = wd[7:0];
                end else begin
                    res[7:0] = wd[7:0];
                end
            end
            adg_pkg::adg_acc_bit: begin
                // single bit set or clear without touching its neighbours
                res[idx] = wd[`ADG_BIT_VAL_POS];
            end
            default: begin
                // unused access code writes nothing
                res = cur;
            end
        endcase
        return res;
    endfunction : merge_write

    // shape a 16-bit value for the bus by access size
    function automatic logic [15:0] shape_read(
        input logic [15:0] val,
        input adg_pkg::adg_acc_t acc,
        input logic high
    );
        logic [15:0] res;
        res = 16'h0000;
        if (acc == adg_pkg::adg_acc_word) begin
            // misaligned word read returns zero
            res = high ? 16'h0000 : val;
        end else begin
            // byte and bit reads return the byte in the low lane
            res = high ? {8'h00, val[15:8]} : {8'h00, val[7:0]};
        end
        return res;
    endfunction : shape_read

    // decode of the register addresses
    always_comb begin
        hit_latch = (bus_req.addr == `ADG_LATCH_OFS) || (bus_req.addr == `ADG_LATCH_HIGH_OFS);
        hit_dir = (bus_req.addr == `ADG_DIR_OFS) || (bus_req.addr == `ADG_DIR_HIGH_OFS);
        hit_func = (bus_req.addr == `ADG_FUNC_OFS) || (bus_req.addr == `ADG_FUNC_HIGH_OFS);
        hit_stat = (bus_req.addr == `ADG_STAT_OFS);
        hit_high = bus_req.addr[0];
        wr_latch = bus_req.wr && hit_latch;
        wr_dir = bus_req.wr && hit_dir;
        wr_func = bus_req.wr && hit_func;
    end

    // next register values from the write path
    always_comb begin
        next_latch = merge_write(port_output_latch, bus_req.acc, hit_high, bus_req.wdata);
        next_dir = merge_write(pin_direction_reg, bus_req.acc, hit_high, bus_req.wdata);
        next_func = merge_write(pin_function_select, bus_req.acc, hit_high, bus_req.wdata);
    end

    // output latch, cleared by reset
    always_ff @(posedge clk) begin
        if (reset) begin
            port_output_latch <= `ADG_LATCH_RST;
        end else if (wr_latch) begin
            port_output_latch <= next_latch;
        end
    end

    // direction register; all inputs after reset so no pin fights the board
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_direction_reg <= `ADG_DIR_RST;
        end else if (wr_dir) begin
            pin_direction_reg <= next_dir;
        end
    end

    // function select register, every pin a port pin after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_function_select <= `ADG_FUNC_RST;
        end else if (wr_func) begin
            pin_function_select <= next_func;
        end
    end

    // latch reads show the pin level for pins set as port inputs
    always_comb begin
        latch_view = (pin_direction_reg & ~pin_function_select & pin_level)
            | (~(pin_direction_reg & ~pin_function_select) & port_output_latch);
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        next_rdata = 16'h0000;
        if (hit_latch) begin
            next_rdata = shape_read(latch_view, bus_req.acc, hit_high);
        end else if (hit_dir) begin
            next_rdata = shape_read(pin_direction_reg, bus_req.acc, hit_high);
        end else if (hit_func) begin
            next_rdata = shape_read(pin_function_select, bus_req.acc, hit_high);
        end else if (hit_stat) begin
            next_rdata[`ADG_STAT_CONFLICT_POS] = upper_bus_conflict;
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 16'h0000;
        end else if (bus_req.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 16'h0000;
        end
    end

    // one cell per pin; flash mode takes pin 5 without register help
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_pin
            adg_pin_cell u_cell (
                .clk(clk),
                .reset(reset),
                .pin_in(pin_in[gi]),
                .latch_bit(port_output_latch[gi]),
                .dir_input(pin_direction_reg[gi]),
                .func_bus(pin_function_select[gi]),
                .bus_out(muxed_addr_data_drive.level[gi]),
                .bus_oe(muxed_addr_data_drive.oe[gi]),
                .force_input(flash_mode && (gi == `ADG_FLASH_PIN)),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi]),
                .pin_level(pin_level[gi])
            );
        end
    endgenerate

    // bus controller sees the synchronised pins of its own bits only
    always_ff @(posedge clk) begin
        if (reset) begin
            muxed_addr_data_bit <= 16'h0000;
        end else begin
            muxed_addr_data_bit <= pin_level & pin_function_select;
        end
    end

    // flash mode level of pin 5, held low outside flash mode
    always_ff @(posedge clk) begin
        if (reset) begin
            flash_mode_pin <= 1'b0;
        end else begin
            flash_mode_pin <= flash_mode && pin_level[`ADG_FLASH_PIN];
        end
    end

    // flag software selecting upper bus pins on an 8-bit separate bus;
    // the hardware cannot refuse it, it only reports it
    always_ff @(posedge clk) begin
        if (reset) begin
            upper_bus_conflict <= 1'b0;
        end else begin
            upper_bus_conflict <= separate_bus_mode_bit
                && (area_bus_width_bits == `ADG_AREA_WIDTH_8BIT)
                && (|pin_function_select[15:8]);
        end
    end

    // checks of the behaviour above
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // a word write to the latch
    sequence latch_word_wr_s;
        bus_req.wr && (bus_req.addr == `ADG_LATCH_OFS) && (bus_req.acc == adg_pkg::adg_acc_word);
    endsequence

    // a byte write to the high latch byte
    sequence latch_high_wr_s;
        bus_req.wr && (bus_req.addr == `ADG_LATCH_HIGH_OFS)
            && (bus_req.acc == adg_pkg::adg_acc_byte);
    endsequence

    // a read of the latch word
    sequence latch_word_rd_s;
        bus_req.rd && (bus_req.addr == `ADG_LATCH_OFS) && (bus_req.acc == adg_pkg::adg_acc_word);
    endsequence

    // a byte write to the low latch byte
    sequence latch_low_wr_s;
        bus_req.wr && (bus_req.addr == `ADG_LATCH_OFS)
            && (bus_req.acc == adg_pkg::adg_acc_byte);
    endsequence

    latch_reset_a: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> (port_output_latch == 16'h0000))
        else $error("latch not cleared by reset");

    func_reset_a: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> (pin_function_select == 16'h0000) && (pin_oe == 16'h0000))
        else $error("function select not cleared by reset");

    latch_word_a: assert property (latch_word_wr_s |=>
        port_output_latch == $past(bus_req.wdata))
        else $error("word write did not reach latch");

    high_byte_a: assert property (latch_high_wr_s |=>
        (port_output_latch[15:8] == $past(bus_req.wdata[7:0]))
        && (port_output_latch[7:0] == $past(port_output_latch[7:0])))
        else $error("high byte write mapped wrongly");

    // the low byte write must leave the high byte alone
    low_byte_a: assert property (latch_low_wr_s |=>
        (port_output_latch[7:0] == $past(bus_req.wdata[7:0]))
        && (port_output_latch[15:8] == $past(port_output_latch[15:8])))
        else $error("low byte write mapped wrongly");

    bit_write_a: assert property (bus_req.wr && (bus_req.addr == `ADG_LATCH_OFS)
        && (bus_req.acc == adg_pkg::adg_acc_bit) |=>
        port_output_latch[$past(bus_req.wdata[2:0])] == $past(bus_req.wdata[3]))
        else $error("bit write did not set latch bit");

    dir_word_a: assert property (bus_req.wr && (bus_req.addr == `ADG_DIR_OFS)
        && (bus_req.acc == adg_pkg::adg_acc_word) |=>
        pin_direction_reg == $past(bus_req.wdata))
        else $error("direction word write lost");

    func_high_a: assert property (bus_req.wr && (bus_req.addr == `ADG_FUNC_HIGH_OFS)
        && (bus_req.acc == adg_pkg::adg_acc_byte) |=>
        pin_function_select[15:8] == $past(bus_req.wdata[7:0]))
        else $error("function high byte write lost");

    pin_drive_a: assert property (!flash_mode && (pin_function_select[0] == 1'b0)
        && (pin_direction_reg[0] == 1'b0) |->
        pin_oe[0] && (pin_out[0] == port_output_latch[0]))
        else $error("port output pin not driving latch");

    // port input pin 8 must never fight whatever drives it from outside
    port_input_a: assert property (!flash_mode && !pin_function_select[8]
        && pin_direction_reg[8] |-> !pin_oe[8])
        else $error("port input pin driven");

    bus_pin_a: assert property (pin_function_select[15] |->
        (pin_out[15] == muxed_addr_data_drive.level[15])
        && (pin_oe[15] == muxed_addr_data_drive.oe[15]))
        else $error("bus pin not following bus controller");

    // port pin 0 stays hidden from the bus controller
    bus_mask_a: assert property (!pin_function_select[0] |=>
        muxed_addr_data_bit[0] == 1'b0)
        else $error("port pin leaked to bus controller");

    flash_pin_a: assert property (flash_mode |-> !pin_oe[`ADG_FLASH_PIN])
        else $error("flash pin driven in flash mode");

    input_read_a: assert property (latch_word_rd_s and
        (pin_direction_reg == 16'hFFFF) and (pin_function_select == 16'h0000)
        |=> rdata == $past(pin_level))
        else $error("input pin level not seen on read");

    // read data must not linger past its one cycle
    rdata_idle_a: assert property (!bus_req.rd |=> rdata == 16'h0000)
        else $error("read data stood outside its cycle");

    conflict_a: assert property (separate_bus_mode_bit
        && (area_bus_width_bits == `ADG_AREA_WIDTH_8BIT)
        && pin_function_select[8] |=> upper_bus_conflict)
        else $error("upper bus conflict not flagged");

    conflict_clear_a: assert property (!separate_bus_mode_bit |=>
        !upper_bus_conflict)
        else $error("upper bus conflict flagged outside separate mode");

endmodule : adg_port

/* File: adg_map.svh */
// register offsets, field positions and reset values of the address/data gpio port
`ifndef ADG_MAP_SVH
`define ADG_MAP_SVH

// output latch: word and low byte share one address, high byte sits one above
`define ADG_LATCH_OFS 32'hFFFF_F004
`define ADG_LATCH_HIGH_OFS 32'hFFFF_F005
// pin direction register
`define ADG_DIR_OFS 32'hFFFF_F024
`define ADG_DIR_HIGH_OFS 32'hFFFF_F025
// pin function select register
`define ADG_FUNC_OFS 32'h0FFF_F044
`define ADG_FUNC_HIGH_OFS 32'h0FFF_F045
// status register: upper bus pin conflict flag
`define ADG_STAT_OFS 32'hFFFF_F0F0

// reset values
`define ADG_LATCH_RST 16'h0000
`define ADG_DIR_RST 16'hFFFF
`define ADG_FUNC_RST 16'h0000

// field positions
`define ADG_BIT_IDX_MSB 2
`define ADG_BIT_VAL_POS 3
`define ADG_FLASH_PIN 5
`define ADG_STAT_CONFLICT_POS 0
`define ADG_AREA_WIDTH_8BIT 4'h0

`endif

/* File: adg_pkg.sv */
// types shared by the address/data gpio port
package adg_pkg;

    // access size of one register bus request
    typedef enum logic [1:0] {
        adg_acc_word,
        adg_acc_byte,
        adg_acc_bit
    } adg_acc_t;

    // one request on the register port
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        adg_acc_t acc;
    } adg_bus_req_t;

    // drive side of one group of pins
    typedef struct packed {
        logic [15:0] level;
        logic [15:0] oe;
    } adg_drive_t;

endpackage : adg_pkg

/* File: adg_pin_cell.sv */
// one pin of the port: input synchroniser and output selection
module adg_pin_cell (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin_in,
    input wire logic latch_bit,
    input wire logic dir_input,
    input wire logic func_bus,
    input wire logic bus_out,
    input wire logic bus_oe,
    input wire logic force_input,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_level
);

    // first stage, read only by the second stage
    logic sync_first;

    // two flip-flops before anything looks at the pin
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_first <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            sync_first <= pin_in;
            pin_level <= sync_first;
        end
    end

    // output mux: flash mode wins, then bus function, then port latch
    always_comb begin
        if (force_input) begin
            // flash mode owns the pin as an input
            pin_out = 1'b0;
            pin_oe = 1'b0;
        end else if (func_bus) begin
            // bus controller drives and turns the pin around
            pin_out = bus_out;
            pin_oe = bus_oe;
        end else begin
            // port mode: latch value drives when direction is output
            pin_out = latch_bit;
            pin_oe = ~dir_input;
        end
    end

endmodule : adg_pin_cell

/* File: adg_ext_mem.sv */
// model of the external memory or peripheral on the address/data pins
module adg_ext_mem (
    input wire logic clk,
    input wire logic [15:0] dev_out,
    input wire logic [15:0] dev_oe,
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_oe,
    output logic [15:0] wire_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last = 16'h0000; // last resolved level of each line
    // device drive wins, then the memory; an undriven line has no pull,
    // so it shows the inverse of its last level and a stale value never passes
    assign wire_lvl = (dev_oe & dev_out) | (~dev_oe & ext_oe & ext_val)
        | (~dev_oe & ~ext_oe & ~last);
    // remember the level for the floating case
    always_ff @(posedge clk) begin
        last <= wire_lvl;
    end
endmodule : adg_ext_mem

/* File: adg_port_tb_top.sv */
// self-checking bench of the address/data gpio port
`include "adg_map.svh"
`define ADG_CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module adg_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // short names for access sizes and addresses
    localparam adg_pkg::adg_acc_t aw = adg_pkg::adg_acc_word;
    localparam adg_pkg::adg_acc_t ab = adg_pkg::adg_acc_byte;
    localparam adg_pkg::adg_acc_t ai = adg_pkg::adg_acc_bit;
    localparam logic [31:0] lo = `ADG_LATCH_OFS;
    localparam logic [31:0] lh = `ADG_LATCH_HIGH_OFS;
    localparam logic [31:0] dl = `ADG_DIR_OFS;
    localparam logic [31:0] dh = `ADG_DIR_HIGH_OFS;
    localparam logic [31:0] fl = `ADG_FUNC_OFS;
    localparam logic [31:0] fh = `ADG_FUNC_HIGH_OFS;
    localparam logic [31:0] st = `ADG_STAT_OFS;
    // state left by the table: function, direction, latch
    localparam logic [15:0] f = 16'hAB24;
    localparam logic [15:0] d = 16'hF001;
    localparam logic [15:0] l = 16'hDA38;
    // one row: a write, then a read with its expected data
    typedef struct {
        logic [31:0] wa;
        adg_pkg::adg_acc_t wk;
        logic [15:0] wd;
        logic [31:0] ra;
        adg_pkg::adg_acc_t rk;
        logic [15:0] ex;
    } adg_row_t;
    adg_row_t rows [14] = '{
        '{dl, aw, 16'h0000, dl, aw, 16'h0000},
        '{lo, aw, 16'hA5C3, lo, aw, 16'hA5C3},
        '{lh, ab, 16'h005A, lo, aw, 16'h5AC3},
        '{lo, ab, 16'h003C, lh, ab, 16'h005A},
        '{lh, ai, 16'h000F, lo, aw, 16'hDA3C},
        '{lo, ai, 16'h0002, lo, aw, 16'hDA38},
        '{dh, ab, 16'h00F0, dl, aw, 16'hF000},
        '{dl, ai, 16'h0008, dl, ab, 16'h0001},
        '{fl, aw, 16'h1234, fl, aw, 16'h1234},
        '{fh, ab, 16'h00AB, fh, ab, 16'h00AB},
        '{fl, ai, 16'h0004, fl, aw, 16'hAB24},
        '{32'h0000_1000, aw, 16'h1234, 32'h0000_1000, aw, 16'h0000},
        '{lh, aw, 16'hFFFF, lh, aw, 16'h0000},
        '{st, aw, 16'hFFFF, st, aw, 16'h0000}
    };
    logic clk = 1'b0;
    logic reset = 1'b1; // synchronous, active high
    adg_pkg::adg_bus_req_t bus_req = '0;
    // bus controller; it drives pin 5 low so that flash mode has a drive to take away
    adg_pkg::adg_drive_t drv = '{level: 16'hC0DE, oe: 16'h0F2F};
    logic [15:0] rdata;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic [15:0] pins; // resolved pin levels
    logic [15:0] madb;
    logic [15:0] ext_val = 16'h9669; // level the memory puts on released pins
    logic flash_mode = 1'b0;
    logic fpin;
    logic sep = 1'b0;
    logic [3:0] width = 4'h1;
    logic conflict;
    logic [15:0] q;
    logic [15:0] oe_x; // expected drive enables
    logic [15:0] out_x; // expected drive levels
    logic [15:0] w_x; // expected wire levels
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    adg_port dut_u (
        .clk(clk),
        .reset(reset),
        .bus_req(bus_req),
        .rdata(rdata),
        .pin_in(pins),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .muxed_addr_data_drive(drv),
        .muxed_addr_data_bit(madb),
        .flash_mode(flash_mode),
        .flash_mode_pin(fpin),
        .separate_bus_mode_bit(sep),
        .area_bus_width_bits(width),
        .upper_bus_conflict(conflict)
    );

    adg_ext_mem mem_u (
        .clk(clk),
        .dev_out(pin_out),
        .dev_oe(pin_oe),
        .ext_val(ext_val),
        .ext_oe(16'hFFFF),
        .wire_lvl(pins)
    );

    // one-cycle write strobe
    task automatic wr(input logic [31:0] a, input adg_pkg::adg_acc_t k, input logic [15:0] v);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0, acc: k};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // one-cycle read strobe; data taken in the cycle after it
    task automatic rd(input logic [31:0] a, input adg_pkg::adg_acc_t k, output logic [15:0] r);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, acc: k};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        r = rdata;
    endtask : rd

    // let n edges pass, then look once outputs settled
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    // report and end the run
    task automatic wrap_up();
        $display("mismatches %0d, compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // a hang is cut short well past the expected hundred or so cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        // register table walk
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wk, rows[i].wd);
            rd(rows[i].ra, rows[i].rk, q);
            `ADG_CHK(q, rows[i].ex)
        end
        // pin drive from latch, direction and function state
        oe_x = (f & drv.oe) | (~f & ~d);
        out_x = (f & drv.level) | (~f & l);
        w_x = (oe_x & out_x) | (~oe_x & ext_val);
        idle(3);
        `ADG_CHK(pin_oe, oe_x)
        `ADG_CHK(pin_out, out_x)
        `ADG_CHK(madb, w_x & f)
        rd(lo, aw, q);
        `ADG_CHK(q, (l & ~(d & ~f)) | (w_x & d & ~f))
        idle(1);
        `ADG_CHK(rdata, 16'h0000)
        // flash mode takes pin 5 away from the bus function
        @(posedge clk);
        flash_mode <= 1'b1;
        idle(3);
        `ADG_CHK(pin_oe[5], 1'b0)
        `ADG_CHK(fpin, ext_val[5])
        // software breaks the upper-pin restriction; the device flags it
        @(posedge clk);
        sep <= 1'b1;
        width <= 4'h0;
        idle(3);
        `ADG_CHK(conflict, 1'b1)
        rd(st, aw, q);
        `ADG_CHK(q, 16'h0001)
        @(posedge clk);
        width <= 4'h1;
        idle(3);
        `ADG_CHK(conflict, 1'b0)
        // second reset in mid-run
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(fl, aw, q);
        `ADG_CHK(q, 16'h0000)
        `ADG_CHK(pin_oe, 16'h0000)
        // all pins are inputs again, so the latch word reads the memory's levels
        rd(lo, aw, q);
        `ADG_CHK(q, ext_val)
        wr(dl, aw, 16'h0000);
        rd(lo, aw, q);
        `ADG_CHK(q, 16'h0000)
        wrap_up();
    end
endmodule : adg_port_tb_top
